// ===== cpm_pkg.sv
package cpm_pkg;
  // Register map of the port
  localparam logic [7:0] CPM_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] CPM_ADDR_SYS_CONFIG = 8'hBF;
  localparam logic [7:0] CPM_ADDR_IRQ_ENABLE = 8'hA8;
  localparam logic [7:0] CPM_ADDR_STATUS = 8'hF0;
  // Power control fields
  localparam int CPM_BIT_IDLE = 0;
  localparam int CPM_BIT_DEEP = 1;
  localparam int CPM_BIT_GF0 = 2;
  localparam int CPM_BIT_GF1 = 3;
  localparam int CPM_BIT_SMOD = 7;
  // System config and irq enable fields
  localparam int CPM_BIT_WAKE_EN = 4;
  localparam int CPM_BIT_GIE = 7;
  localparam int CPM_BIT_EX0 = 0;
  localparam int CPM_BIT_EX1 = 2;
  // Reset values
  localparam logic [7:0] CPM_RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] CPM_RST_SYS_CONFIG = 8'h02;
  localparam logic [7:0] CPM_RST_IRQ_ENABLE = 8'h00;
  // Restart vectors
  localparam logic [15:0] CPM_VEC_RESET = 16'h0000;
  localparam logic [15:0] CPM_VEC_EXT0 = 16'h0003;
  localparam logic [15:0] CPM_VEC_EXT1 = 16'h0013;
  // Debounce interval after an external wake
  localparam int CPM_DEBOUNCE_NS = 100000;
  localparam int CPM_CLK_NS = 100;
  localparam int CPM_DEBOUNCE_CYC = (CPM_DEBOUNCE_NS + CPM_CLK_NS - 1) / CPM_CLK_NS;
  localparam int CPM_CNT_W = 10;
  typedef enum logic [1:0] {
    CPM_RUN = 2'b00,
    CPM_IDLE = 2'b01,
    CPM_DOWN = 2'b10,
    CPM_SETTLE = 2'b11
  } cpm_state_t;
endpackage

// ===== cpm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpm_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

// ===== cpm_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_debounce
  import cpm_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  cpm_if.timer ctl
);
  logic [CPM_CNT_W-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      if (ctl.start) begin
        count_reg <= CPM_CNT_W'(CPM_DEBOUNCE_CYC - 1);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (count_reg == '0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

  assign ctl.busy = busy_reg;
  assign ctl.done = done_reg;
endmodule // cpm_debounce
`default_nettype wire

// ===== cpm_stop_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_stop_regs
  import cpm_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic clk_en,
  // Retained word store
  input wire logic hold,
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // No reset: contents persist across power-down
  logic [7:0] mem [0:15];
  always_ff @(posedge clk) begin
    if (clk_en && !hold) begin
      if (wr) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule // cpm_stop_regs
`default_nettype wire

// ===== cpm_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_power_ctrl
  import cpm_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt sources
  input wire logic ext_wake_pin0,
  input wire logic ext_wake_pin1,
  input wire logic [4:0] other_irq,
  // Retained store access
  input wire logic store_wr,
  input wire logic [3:0] store_addr,
  input wire logic [7:0] store_wdata,
  output logic [7:0] store_rdata,
  // Clock and CPU control
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [15:0] restart_vector,
  // Pin status
  output logic address_latch_strobe,
  output logic program_store_strobe,
  output logic port0_float,
  output logic port2_addr_sel,
  output logic ext_prog_mem
);
  cpm_state_t state_reg;
  cpm_state_t state_next;
  logic [7:0] power_control_reg;
  logic [7:0] sys_config_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] rdata_reg;
  logic [1:0] wake_src_reg;
  logic wake_pin0;
  logic wake_pin1;
  logic any_irq;
  logic wr_pc;
  cpm_if deb ();
  logic deb_start_reg;

  // Enable gating shared by all sources
  function automatic logic gated(input logic gie, input logic en, input logic req);
    gated = gie & en & req;
  endfunction

  assign wake_pin0 = gated(irq_enable_reg[CPM_BIT_GIE], irq_enable_reg[CPM_BIT_EX0],
                           ext_wake_pin0) & sys_config_reg[CPM_BIT_WAKE_EN];
  assign wake_pin1 = gated(irq_enable_reg[CPM_BIT_GIE], irq_enable_reg[CPM_BIT_EX1],
                           ext_wake_pin1) & sys_config_reg[CPM_BIT_WAKE_EN];
  assign any_irq = gated(irq_enable_reg[CPM_BIT_GIE], irq_enable_reg[CPM_BIT_EX0],
                         ext_wake_pin0)
                 | gated(irq_enable_reg[CPM_BIT_GIE], irq_enable_reg[CPM_BIT_EX1],
                         ext_wake_pin1)
                 | gated(irq_enable_reg[CPM_BIT_GIE], 1'b1, |other_irq);
  assign wr_pc = reg_wr && reg_addr == CPM_ADDR_POWER_CONTROL;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CPM_RUN: begin
        if (wr_pc && reg_wdata[CPM_BIT_DEEP]) begin
          state_next = CPM_DOWN;
        end else if (wr_pc && reg_wdata[CPM_BIT_IDLE]) begin
          state_next = CPM_IDLE;
        end
      end
      CPM_IDLE: begin
        if (any_irq) begin
          state_next = CPM_RUN;
        end
      end
      CPM_DOWN: begin
        if (wake_pin0 || wake_pin1) begin
          state_next = CPM_SETTLE;
        end
      end
      CPM_SETTLE: begin
        if (deb.done) begin
          state_next = CPM_RUN;
        end
      end
    endcase
  end

  // Reset pin acts through reset_n in every state, ending idle or power-down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CPM_RUN;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Request bits never stored; both always read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_control_reg <= CPM_RST_POWER_CONTROL;
      sys_config_reg <= CPM_RST_SYS_CONFIG;
      irq_enable_reg <= CPM_RST_IRQ_ENABLE;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        CPM_ADDR_POWER_CONTROL: begin
          power_control_reg <= reg_wdata & 8'h8C;
        end
        CPM_ADDR_SYS_CONFIG: begin
          sys_config_reg <= reg_wdata;
        end
        CPM_ADDR_IRQ_ENABLE: begin
          irq_enable_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          CPM_ADDR_POWER_CONTROL: rdata_reg <= power_control_reg;
          CPM_ADDR_SYS_CONFIG: rdata_reg <= sys_config_reg;
          CPM_ADDR_IRQ_ENABLE: rdata_reg <= irq_enable_reg;
          CPM_ADDR_STATUS: rdata_reg <= {4'h0, wake_src_reg, state_reg};
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_reg;

  // Remember which pin woke the part so its routine runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_src_reg <= 2'b00;
      deb_start_reg <= 1'b0;
    end else if (clk_en) begin
      deb_start_reg <= 1'b0;
      if (state_reg == CPM_DOWN && state_next == CPM_SETTLE) begin
        wake_src_reg <= wake_pin0 ? 2'b01 : 2'b10;
        deb_start_reg <= 1'b1;
      end else if (state_reg == CPM_RUN && wr_pc) begin
        wake_src_reg <= 2'b00;
      end
    end
  end
  assign deb.start = deb_start_reg;

  cpm_debounce u_debounce (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .ctl(deb)
  );

  // Store is frozen while the oscillator is off
  cpm_stop_regs u_store (
    .clk(clk),
    .clk_en(clk_en),
    .hold(state_reg == CPM_DOWN || state_reg == CPM_SETTLE),
    .wr(store_wr),
    .addr(store_addr),
    .wdata(store_wdata),
    .rdata(store_rdata)
  );

  // Mode outputs registered from the next state so they track the mode exactly; irq_req from the current state, ext_prog_mem from sys config
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      irq_req <= 1'b0;
      irq_vector <= CPM_VEC_RESET;
      restart_vector <= CPM_VEC_RESET;
      address_latch_strobe <= 1'b0;
      program_store_strobe <= 1'b0;
      port0_float <= 1'b0;
      port2_addr_sel <= 1'b0;
      ext_prog_mem <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_en <= state_next == CPM_RUN;
      periph_clk_en <= state_next != CPM_DOWN && state_next != CPM_SETTLE;
      osc_en <= state_next != CPM_DOWN;
      // Return address is the CPU's own next PC, held since its clock stopped
      irq_req <= (state_reg == CPM_IDLE && any_irq) || deb.done;
      if (deb.done) begin
        irq_vector <= wake_src_reg[0] ? CPM_VEC_EXT0 : CPM_VEC_EXT1;
      end
      address_latch_strobe <= state_next == CPM_IDLE;
      program_store_strobe <= state_next == CPM_IDLE;
      port0_float <= sys_config_reg[1] && state_next != CPM_RUN;
      port2_addr_sel <= sys_config_reg[1] && state_next == CPM_IDLE;
      ext_prog_mem <= sys_config_reg[1];
    end
  end
endmodule // cpm_power_ctrl
`default_nettype wire

// ===== cpm_power_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_power_ctrl_asserts
  import cpm_pkg::*;
(
  // Clock, reset and register writes
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Pins and mode outputs
  input wire logic ext_wake_pin0,
  input wire logic ext_wake_pin1,
  input wire logic cpu_clk_en,
  input wire logic osc_en,
  input wire logic irq_req,
  input wire logic address_latch_strobe,
  input wire logic program_store_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic pw;
  assign pw = clk_en && reg_wr && reg_addr == CPM_ADDR_POWER_CONTROL && cpu_clk_en;
  chk_idle_entry: assert property (pw && reg_wdata[1:0] == 2'h1 |=> address_latch_strobe)
    else $error("idle not entered");
  chk_deep_entry: assert property (pw && reg_wdata[1] |=> !osc_en)
    else $error("power-down not entered");
  chk_idle_pins: assert property (
    address_latch_strobe |-> program_store_strobe && osc_en && !cpu_clk_en)
    else $error("idle pins wrong");
  chk_down_pins: assert property (
    !osc_en |-> !address_latch_strobe && !program_store_strobe && !cpu_clk_en)
    else $error("power-down pins wrong");
  chk_run_strobe: assert property (cpu_clk_en |-> !address_latch_strobe)
    else $error("strobe high in run");
  chk_no_wake: assert property (
    !osc_en && !ext_wake_pin0 && !ext_wake_pin1 |=> !osc_en)
    else $error("wake without pin");
  chk_settle_hold: assert property ($rose(osc_en) |-> !cpu_clk_en [*8])
    else $error("cpu ran before settle");
  // Cycles since the oscillator restarted; too long for a delay range, so counted here
  logic osc_prev;
  int settle_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev <= 1'b1;
      settle_cnt <= 0;
    end else if (clk_en) begin
      osc_prev <= osc_en;
      if (osc_en && !osc_prev) begin
        settle_cnt <= 1;
      end else if (settle_cnt != 0 && !irq_req) begin
        settle_cnt <= settle_cnt + 1;
      end else begin
        settle_cnt <= 0;
      end
    end
  end
  chk_settle_len: assert property (
    settle_cnt != 0 && irq_req |-> settle_cnt >= CPM_DEBOUNCE_CYC - 5
      && settle_cnt <= CPM_DEBOUNCE_CYC + 5)
    else $error("settle length wrong");
  chk_settle_max: assert property (settle_cnt <= CPM_DEBOUNCE_CYC + 5)
    else $error("settle never ended");
  cover property ($rose(address_latch_strobe));
  cover property ($fell(osc_en));
  cover property (irq_req ##1 cpu_clk_en);
endmodule // cpm_power_ctrl_asserts
bind cpm_power_ctrl cpm_power_ctrl_asserts u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .ext_wake_pin0(ext_wake_pin0),
  .ext_wake_pin1(ext_wake_pin1),
  .cpu_clk_en(cpu_clk_en),
  .osc_en(osc_en),
  .irq_req(irq_req),
  .address_latch_strobe(address_latch_strobe),
  .program_store_strobe(program_store_strobe)
);
`default_nettype wire

// ===== cpm_wake_src.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_wake_src #(
  parameter int HOLD = 4
) (
  // Requests: bit 0 pin0, bit 1 pin1, bit 2 reset pin
  input wire logic clk,
  input wire logic [2:0] fire,
  // Source lines, wake pins idle low, rst_pin_n idles high
  output logic ext_wake_pin0,
  output logic ext_wake_pin1,
  output logic rst_pin_n
);
  // Reset hold scaled down from the long settle time to keep the run short
  int cnt [3] = '{0, 0, 0};
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      cnt[i] <= fire[i] ? HOLD : (cnt[i] > 0 ? cnt[i] - 1 : 0);
    end
  end
  assign ext_wake_pin0 = cnt[0] > 0;
  assign ext_wake_pin1 = cnt[1] > 0;
  assign rst_pin_n = cnt[2] == 0;
endmodule // cpm_wake_src
`default_nettype wire

// ===== cpu_power_mode_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_power_mode_controller_test;
  import cpm_pkg::*;
  logic clk = 1'h0, por_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, clk_en = 1'h1;
  logic store_wr = 1'h0;
  logic [4:0] other_irq = 5'h00;
  logic [3:0] store_addr = 4'h0;
  logic [2:0] fire = 3'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, store_wdata = 8'h00, reg_rdata, store_rdata;
  logic [15:0] irq_vector, restart_vector;
  logic reset_n, rst_pin_n, ext_wake_pin0, ext_wake_pin1, cpu_clk_en, periph_clk_en, osc_en;
  logic irq_req, address_latch_strobe, program_store_strobe, port0_float, port2_addr_sel;
  logic ext_prog_mem;
  int errors = 0, n_tests = 0, cyc = 0, k;
  assign reset_n = por_n & rst_pin_n;
  cpm_power_ctrl u_cpm_power_ctrl (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ext_wake_pin0(ext_wake_pin0),
    .ext_wake_pin1(ext_wake_pin1),
    .other_irq(other_irq),
    .store_wr(store_wr),
    .store_addr(store_addr),
    .store_wdata(store_wdata),
    .store_rdata(store_rdata),
    .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en),
    .osc_en(osc_en),
    .irq_req(irq_req),
    .irq_vector(irq_vector),
    .restart_vector(restart_vector),
    .address_latch_strobe(address_latch_strobe),
    .program_store_strobe(program_store_strobe),
    .port0_float(port0_float),
    .port2_addr_sel(port2_addr_sel),
    .ext_prog_mem(ext_prog_mem)
  );
  cpm_wake_src u_cpm_wake_src (.clk, .fire, .ext_wake_pin0, .ext_wake_pin1, .rst_pin_n);
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    // Read data stand for this cycle only; look mid-cycle, not at the edge that clears them
    @(negedge clk);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
    @(posedge clk);
  endtask
  task automatic st_wr(input logic [3:0] a, input logic [7:0] d);
    store_addr <= a;
    store_wdata <= d;
    store_wr <= 1'h1;
    @(posedge clk);
    store_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic st_rd(input logic [3:0] a, input logic [7:0] e);
    store_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("store", {8'h00, e}, {8'h00, store_rdata});
    @(posedge clk);
  endtask
  task automatic pulse(input logic [2:0] m, input int n);
    fire <= m;
    @(posedge clk);
    fire <= 3'h0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wirq();
    // The request stands one cycle; sample it mid-cycle
    for (k = 0; k < 1500 && irq_req !== 1'h1; k++) begin
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task automatic t_regs();
    rd(CPM_ADDR_POWER_CONTROL, CPM_RST_POWER_CONTROL);
    rd(CPM_ADDR_SYS_CONFIG, CPM_RST_SYS_CONFIG);
    rd(CPM_ADDR_IRQ_ENABLE, CPM_RST_IRQ_ENABLE);
    rd(8'h55, 8'h00);
    wr(CPM_ADDR_POWER_CONTROL, 8'h8C);
    rd(CPM_ADDR_POWER_CONTROL, 8'h8C);
  endtask
  task automatic t_idle();
    wr(CPM_ADDR_IRQ_ENABLE, 8'h05);
    wr(CPM_ADDR_POWER_CONTROL, 8'h01);
    chk("idle", 16'h0F, {cpu_clk_en, periph_clk_en, address_latch_strobe,
      program_store_strobe, port2_addr_sel});
    pulse(3'h1, 8);
    chk("masked", 16'h0, cpu_clk_en);
    pulse(3'h4, 6);
    chk("reset", 16'h1, cpu_clk_en);
    rd(CPM_ADDR_IRQ_ENABLE, 8'h00);
    wr(CPM_ADDR_IRQ_ENABLE, 8'h81);
    wr(CPM_ADDR_POWER_CONTROL, 8'h01);
    pulse(3'h1, 0);
    wirq();
    @(posedge clk);
    chk("wake", 16'h1, cpu_clk_en);
    rd(CPM_ADDR_POWER_CONTROL, 8'h00);
    wr(CPM_ADDR_POWER_CONTROL, 8'h01);
    other_irq <= 5'h04;
    wirq();
    other_irq <= 5'h00;
    chk("other wake", 16'h1, cpu_clk_en);
  endtask
  task automatic t_down(input logic [2:0] m, input logic [15:0] vec);
    wr(CPM_ADDR_IRQ_ENABLE, 8'h85);
    wr(CPM_ADDR_SYS_CONFIG, 8'h12);
    st_wr(4'h5, 8'hA5);
    wr(CPM_ADDR_POWER_CONTROL, 8'h07);
    chk("down", 16'h05, {osc_en, address_latch_strobe, program_store_strobe,
      port0_float, port2_addr_sel, ext_prog_mem});
    // A write attempt while the oscillator is off must not reach the store
    st_wr(4'h5, 8'h5A);
    pulse(m, 0);
    wirq();
    chk("vector", vec, irq_vector);
    chk("settle", 16'h1, {15'h0, k > 994 && k < 1011});
    rd(CPM_ADDR_POWER_CONTROL, 8'h04);
    st_rd(4'h5, 8'hA5);
  endtask
  task automatic t_down_rst();
    wr(CPM_ADDR_SYS_CONFIG, 8'h02);
    wr(CPM_ADDR_POWER_CONTROL, 8'h02);
    pulse(3'h1, 8);
    chk("no wake", 16'h0, osc_en);
    pulse(3'h4, 6);
    chk("rst wake", 16'h1, osc_en);
    chk("restart", CPM_VEC_RESET, restart_vector);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    por_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_idle();
    t_down(3'h1, CPM_VEC_EXT0);
    t_down(3'h2, CPM_VEC_EXT1);
    t_down_rst();
    results();
  end
endmodule // cpu_power_mode_controller_test
`default_nettype wire
